// file: rtl/afr_link.sv
// Two-wire bus target running on the link clock, with toggle handshakes to the core
module afr_link import afr_pkg::*; #(
   parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
   // Link clock and reset from the core domain
   input wire logic link_clk,
   input wire logic rst_n,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_oe,
   output logic sda_oe,
   // Read word handshake
   output logic req_tgl,
   input wire logic ack_tgl,
   input wire logic [15:0] word,
   // Command handshake
   output logic cmd_tgl,
   output logic [7:0] cmd_byte,
   output logic cmd_extra
);

   // ****************************************************************
   // Synchronisers
   // ****************************************************************
   logic rst_s1, rst_s2;
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;
   logic ack_s1, ack_s2;

   always_ff @(posedge link_clk) begin
      rst_s1 <= rst_n;
      rst_s2 <= rst_s1;
   end

   always_ff @(posedge link_clk) begin
      if (!rst_s2) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   logic scl_rise, scl_fall, start_seen, stop_seen;
   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ****************************************************************
   // Bus sequencer
   // ****************************************************************
   afr_link_t st;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [15:0] tx_sh;
   logic byte_sel, host_ack, loaded, ack_seen;
   logic [3:0] hold_cnt;
   logic [1:0] wr_cnt;

   always_ff @(posedge link_clk) begin
      if (!rst_s2) begin
         st <= L_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         tx_sh <= 16'h0000;
         byte_sel <= 1'b0;
         host_ack <= 1'b0;
         loaded <= 1'b0;
         ack_seen <= 1'b0;
         hold_cnt <= 4'h0;
         wr_cnt <= 2'h0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         req_tgl <= 1'b0;
         cmd_tgl <= 1'b0;
         cmd_byte <= 8'h00;
         cmd_extra <= 1'b0;
      end else if (start_seen || stop_seen) begin
         // A written transaction ends here; hand its command to the core
         if (wr_cnt != 2'h0) begin
            cmd_tgl <= ~cmd_tgl;
            cmd_extra <= (wr_cnt > 2'h1);
         end
         wr_cnt <= 2'h0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
         bit_cnt <= 4'h0;
         st <= start_seen ? L_ADDR : L_IDLE;
      end else begin
         case (st)
            L_ADDR: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (shift[7:1] == TARGET_ADDR) begin
                     sda_oe <= 1'b1;
                     st <= L_AACK;
                  end else begin
                     st <= L_IDLE;
                  end
               end
            end
            L_AACK: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  if (shift[0]) begin
                     // Stretch SCL until the core has picked the answer word
                     req_tgl <= ~req_tgl;
                     scl_oe <= 1'b1;
                     byte_sel <= 1'b0;
                     loaded <= 1'b0;
                     hold_cnt <= 4'h0;
                     st <= L_WAIT;
                  end else begin
                     st <= L_RX;
                  end
               end
            end
            L_RX: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (wr_cnt == 2'h0) begin
                     cmd_byte <= shift;
                  end
                  if (wr_cnt != 2'h2) begin
                     wr_cnt <= wr_cnt + 2'h1;
                  end
                  sda_oe <= 1'b1;
                  st <= L_RACK;
               end
            end
            L_RACK: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  st <= L_RX;
               end
            end
            L_WAIT: begin
               if (!loaded) begin
                  if (ack_s2 != ack_seen) begin
                     ack_seen <= ack_s2;
                     tx_sh <= word;
                     sda_oe <= ~word[15];
                     loaded <= 1'b1;
                  end
               end else if (hold_cnt == TX_SETUP_CYC) begin
                  // Data has settled; let the host clock it
                  scl_oe <= 1'b0;
                  bit_cnt <= 4'h0;
                  st <= L_TX;
               end else begin
                  hold_cnt <= hold_cnt + 4'h1;
               end
            end
            L_TX: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     bit_cnt <= 4'h0;
                     st <= L_TACK;
                  end else begin
                     tx_sh <= {tx_sh[14:0], 1'b0};
                     sda_oe <= ~tx_sh[14];
                  end
               end
            end
            L_TACK: begin
               if (scl_rise) begin
                  host_ack <= ~sda_s2;
               end else if (scl_fall) begin
                  if (host_ack && !byte_sel) begin
                     // Low byte follows the high byte
                     byte_sel <= 1'b1;
                     tx_sh <= {tx_sh[14:0], 1'b0};
                     sda_oe <= ~tx_sh[14];
                     st <= L_TX;
                  end else begin
                     st <= L_IDLE;
                  end
               end
            end
            default: begin
               st <= L_IDLE;
            end
         endcase
      end
   end

endmodule

// file: rtl/afr_pkg.sv
// Constants, types and helper functions shared by the airflow readout design
package afr_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned STARTUP_MS = 35;
   localparam int unsigned STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
   localparam int unsigned RESP_TIME_US = 1000;
   localparam int unsigned RESP_CYC = RESP_TIME_US * (CLK_HZ / 1_000_000);
   // Link clock cycles between data setup and releasing a stretched SCL
   localparam logic [3:0] TX_SETUP_CYC = 4'hF;

   // ****************************************************************
   // Command bytes and answer words
   // ****************************************************************
   localparam logic [7:0] READ_UNIT_ID_CMD = 8'h01;
   localparam logic [7:0] FORCED_RESTART_CMD = 8'h02;
   localparam logic [7:0] MEMORY_SUM_CMD = 8'h03;

   localparam logic [15:0] CMD_OK_CODE = 16'hCCA5;
   localparam logic [15:0] UNKNOWN_CMD_CODE = 16'hCC99;
   localparam logic [15:0] WRONG_PARAM_CODE = 16'hCC9A;
   localparam logic [15:0] CMD_FAIL_CODE = 16'hCC9B;
   localparam logic [15:0] MEMORY_SUM_MISMATCH_CODE = 16'hCC90;
   localparam logic [15:0] SUM_BUSY_CODE = 16'hCCBB;

   // ****************************************************************
   // Flow transfer function
   // ****************************************************************
   // Code = 16384 * (0.1 + 0.8 * frac / 65536) = (frac + 8192) / 5
   localparam logic [16:0] FLOW_OFFSET = 17'h02000;
   localparam logic [16:0] FLOW_DIVISOR = 17'h00005;

   // ****************************************************************
   // Stored memory covered by the checksum
   // ****************************************************************
   localparam int unsigned MEM_WORDS = 8;
   localparam logic [2:0] MEM_LAST = 3'h7;
   // Words 0 and 1 hold the unit id, the rest are calibration constants
   localparam logic [5:0][15:0] CAL_INIT = {
      16'h0A11, 16'h3C4D, 16'h5E6F, 16'h7081, 16'h92A3, 16'hB4C5
   };

   function automatic logic [15:0] mem_word(input logic [31:0] unit_id,
                                            input logic [2:0] idx);
      logic [2:0] cal_idx;
      cal_idx = idx - 3'h2;
      case (idx)
         3'h0: mem_word = unit_id[31:16];
         3'h1: mem_word = unit_id[15:0];
         default: mem_word = CAL_INIT[cal_idx];
      endcase
   endfunction

   function automatic logic [15:0] mem_sum(input logic [31:0] unit_id);
      logic [15:0] acc;
      acc = 16'h0000;
      for (int i = 0; i < MEM_WORDS; i++) begin
         acc = acc + mem_word(unit_id, 3'(i));
      end
      mem_sum = acc;
   endfunction

   // ****************************************************************
   // State encodings
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_ID_HI = 3'b000,
      ST_ID_LO = 3'b001,
      ST_FLOW = 3'b011,
      ST_CODE = 3'b010,
      ST_SUMMING = 3'b110
   } afr_state_t;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_AACK = 3'b011,
      L_RX = 3'b010,
      L_RACK = 3'b110,
      L_WAIT = 3'b111,
      L_TX = 3'b101,
      L_TACK = 3'b100
   } afr_link_t;

endpackage

// file: rtl/afr_top.sv
// Airflow sensor readout: flow code, unit id, command handling and checksum test
//
// Summary of operation
// - Flow code is 16384 times (0.1 plus 0.8 times flow over full scale).
// - After power-up, first read gives unit id high half, second the low half.
// - First valid flow measurement is ready within 35 ms of power-up.
// - After the power-up id reads, reads return a two-byte flow reading except while a command's answer words are due.
// - Flow is refreshed every 1 ms; faster reads may see a stale value.
// - Both top bits of every flow reading are zero.
// - Every status or error word has both top bits set.
// - The read right after a command byte returns that command's answer word.
// - Command 0x01 makes the next two reads return the unit id halves.
// - Command 0x02 restarts the internal controller as at power-up.
// - Command 0x03 sums stored memory; answers 0xCCA5 on match, else 0xCC90.
// - While the sum runs, reads return the busy word 0xCCBB.
// - A successful command without data of its own answers 0xCCA5; command 0x02 is answered with the unit id halves instead.
// - An unrecognised command byte answers 0xCC99.
// - A command with extra parameter bytes answers 0xCC9A.
// - A recognised command that fails while executing answers 0xCC9B.
module afr_top import afr_pkg::*; #(
   parameter logic [6:0] TARGET_ADDR = 7'h2A,
   // Arbitrary unit id value
   parameter logic [31:0] UNIT_ID = 32'h5A3C_96E1,
   parameter logic [15:0] MEM_SUM_EXPECTED = mem_sum(UNIT_ID),
   parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
   parameter int unsigned REFRESH_CYCLES = RESP_CYC
) (
   // System clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Sensing front end, flow as a fraction of full scale
   input wire logic [15:0] FLOW_FRAC,
   // Two-wire link
   input wire logic LINK_CLK,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Status
   output logic FLOW_READY,
   output logic SUM_BUSY
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] flow_code(input logic [15:0] frac);
      logic [16:0] num;
      logic [16:0] quo;
      num = {1'b0, frac} + FLOW_OFFSET;
      quo = num / FLOW_DIVISOR;
      // Quotient never exceeds 14745, so the top two bits stay clear
      flow_code = {2'b00, quo[13:0]};
   endfunction

   // ****************************************************************
   // Link side
   // ****************************************************************
   logic req_tgl, cmd_tgl, cmd_extra;
   logic [7:0] cmd_byte;
   logic ack_tgl_reg;
   logic [15:0] word_reg;

   // Open drain: only ever pull low
   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;

   afr_link #(
      .TARGET_ADDR(TARGET_ADDR)
   ) u_link (
      .link_clk(LINK_CLK),
      .rst_n(RST_N),
      .scl_in(SCL_IN),
      .sda_in(SDA_IN),
      .scl_oe(SCL_OE),
      .sda_oe(SDA_OE),
      .req_tgl(req_tgl),
      .ack_tgl(ack_tgl_reg),
      .word(word_reg),
      .cmd_tgl(cmd_tgl),
      .cmd_byte(cmd_byte),
      .cmd_extra(cmd_extra)
   );

   // ****************************************************************
   // Crossing into the core clock
   // ****************************************************************
   logic req_s1, req_s2, cmd_s1, cmd_s2;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         cmd_s1 <= 1'b0;
         cmd_s2 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         cmd_s1 <= cmd_tgl;
         cmd_s2 <= cmd_s1;
      end
   end

   logic req_seen_reg, cmd_seen_reg;
   logic cmd_pend, rd_pend;
   // A command is serviced first; a pending read waits one cycle, never lost
   assign cmd_pend = (cmd_s2 != cmd_seen_reg);
   assign rd_pend = (req_s2 != req_seen_reg) && !cmd_pend;

   // ****************************************************************
   // Restart
   // ****************************************************************
   afr_state_t st_reg;
   logic restart_reg;
   logic core_rst_n;
   logic restart_hit;

   assign restart_hit = cmd_pend && !cmd_extra && cmd_byte == FORCED_RESTART_CMD
      && st_reg != ST_SUMMING;
   // The restart pulse clears startup, flow, state and checksum registers as a power-up would; the link handshake registers keep their values
   assign core_rst_n = RST_N & ~restart_reg;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= restart_hit;
      end
   end

   // ****************************************************************
   // Startup and flow refresh
   // ****************************************************************
   logic [19:0] boot_cnt_reg;
   logic boot_done_reg;

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         boot_cnt_reg <= 20'h00000;
         boot_done_reg <= 1'b0;
      end else if (!boot_done_reg) begin
         if (boot_cnt_reg == 20'(STARTUP_CYCLES - 1)) begin
            boot_done_reg <= 1'b1;
         end else begin
            boot_cnt_reg <= boot_cnt_reg + 20'h00001;
         end
      end
   end

   logic [14:0] refresh_cnt_reg;
   logic [15:0] flow_reg;

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         refresh_cnt_reg <= 15'h0000;
         flow_reg <= 16'h0000;
      end else if (boot_done_reg) begin
         // Sampled once per response time; reads in between see the held value
         if (refresh_cnt_reg == 15'h0000) begin
            flow_reg <= flow_code(FLOW_FRAC);
         end
         if (refresh_cnt_reg == 15'(REFRESH_CYCLES - 1)) begin
            refresh_cnt_reg <= 15'h0000;
         end else begin
            refresh_cnt_reg <= refresh_cnt_reg + 15'h0001;
         end
      end
   end

   assign FLOW_READY = boot_done_reg;

   // ****************************************************************
   // Answer word selection
   // ****************************************************************
   logic [15:0] code_reg;
   logic [15:0] word_next;

   always_comb begin
      case (st_reg)
         ST_ID_HI: word_next = UNIT_ID[31:16];
         ST_ID_LO: word_next = UNIT_ID[15:0];
         ST_FLOW: word_next = flow_reg;
         ST_CODE: word_next = code_reg;
         ST_SUMMING: word_next = SUM_BUSY_CODE;
         default: word_next = flow_reg;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         req_seen_reg <= 1'b0;
         cmd_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         word_reg <= 16'h0000;
      end else if (cmd_pend) begin
         cmd_seen_reg <= cmd_s2;
      end else if (rd_pend) begin
         // Word is held stable until the next request
         req_seen_reg <= req_s2;
         word_reg <= word_next;
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // ****************************************************************
   // Command decode, read sequencing and checksum engine
   // ****************************************************************
   logic [2:0] sum_idx_reg;
   logic [15:0] sum_acc_reg;
   logic [15:0] sum_final;

   assign sum_final = sum_acc_reg + mem_word(UNIT_ID, sum_idx_reg);

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         st_reg <= ST_ID_HI;
         code_reg <= 16'h0000;
         sum_idx_reg <= 3'h0;
         sum_acc_reg <= 16'h0000;
      end else if (cmd_pend) begin
         if (cmd_extra) begin
            st_reg <= ST_CODE;
            code_reg <= WRONG_PARAM_CODE;
         end else if (st_reg == ST_SUMMING) begin
            // A new command aborts the running sum, which then counts as failed
            st_reg <= ST_CODE;
            code_reg <= CMD_FAIL_CODE;
         end else begin
            case (cmd_byte)
               READ_UNIT_ID_CMD: begin
                  st_reg <= ST_ID_HI;
               end
               FORCED_RESTART_CMD: begin
                  st_reg <= ST_ID_HI;
               end
               MEMORY_SUM_CMD: begin
                  st_reg <= ST_SUMMING;
                  sum_idx_reg <= 3'h0;
                  sum_acc_reg <= 16'h0000;
               end
               default: begin
                  st_reg <= ST_CODE;
                  code_reg <= UNKNOWN_CMD_CODE;
               end
            endcase
         end
      end else if (rd_pend) begin
         case (st_reg)
            ST_ID_HI: st_reg <= ST_ID_LO;
            ST_ID_LO: st_reg <= ST_FLOW;
            ST_CODE: st_reg <= ST_FLOW;
            default: st_reg <= st_reg;
         endcase
      end else if (st_reg == ST_SUMMING) begin
         sum_acc_reg <= sum_final;
         sum_idx_reg <= sum_idx_reg + 3'h1;
         if (sum_idx_reg == MEM_LAST) begin
            st_reg <= ST_CODE;
            if (sum_final == MEM_SUM_EXPECTED) begin
               code_reg <= CMD_OK_CODE;
            end else begin
               code_reg <= MEMORY_SUM_MISMATCH_CODE;
            end
         end
      end
   end

   assign SUM_BUSY = (st_reg == ST_SUMMING);

endmodule

// file: tb/afr_checker.sv
// Port checker for the airflow readout top
module afr_checker #(
   parameter int unsigned STARTUP_CYCLES = 700000
) (
   // Clocks and reset
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic LINK_CLK,
   // Link
   input wire logic SCL_IN,
   input wire logic SCL_OUT,
   input wire logic SCL_OE,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   // Status
   input wire logic FLOW_READY,
   input wire logic SUM_BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cycles waited for valid flow since reset or restart
   int unsigned low_cnt_reg;
   always_ff @(posedge CLK) begin
      if (!RST_N || FLOW_READY) begin
         low_cnt_reg <= 0;
      end else begin
         low_cnt_reg <= low_cnt_reg + 1;
      end
   end
   sequence s_busy_run;
      SUM_BUSY [*6];
   endsequence
   sequence s_restart_low;
      !FLOW_READY [*8];
   endsequence
   property p_open_drain;
      @(posedge CLK) disable iff (!RST_N) SCL_OUT == 1'b0 && SDA_OUT == 1'b0;
   endproperty
   property p_not_early;
      @(posedge CLK) disable iff (!RST_N) $rose(RST_N) |-> !FLOW_READY;
   endproperty
   // A small slack covers the synchronous restart path
   property p_ready_time;
      @(posedge CLK) disable iff (!RST_N) $rose(FLOW_READY) |->
         low_cnt_reg + 3 >= STARTUP_CYCLES && low_cnt_reg <= STARTUP_CYCLES + 3;
   endproperty
   property p_ready_deadline;
      @(posedge CLK) disable iff (!RST_N) !FLOW_READY |-> low_cnt_reg <= STARTUP_CYCLES + 3;
   endproperty
   property p_busy_len;
      @(posedge CLK) disable iff (!RST_N) $rose(SUM_BUSY) |-> s_busy_run ##[1:4] !SUM_BUSY;
   endproperty
   property p_restart;
      @(posedge CLK) disable iff (!RST_N) $fell(FLOW_READY) |-> s_restart_low;
   endproperty
   property p_stretch_low;
      @(posedge LINK_CLK) disable iff (!RST_N) $rose(SCL_OE) |-> !SCL_IN;
   endproperty
   property p_stretch_len;
      @(posedge LINK_CLK) disable iff (!RST_N) $rose(SCL_OE) |-> ##[1:300] !SCL_OE;
   endproperty
   // A data change while SCL is high would look like a START or STOP
   property p_sda_steady;
      @(posedge LINK_CLK) disable iff (!RST_N) SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("link outputs driven high");
   a_not_early: assert property (p_not_early) else $error("flow ready at reset release");
   a_ready_time: assert property (p_ready_time) else $error("flow ready at wrong time");
   a_ready_deadline: assert property (p_ready_deadline) else $error("flow ready late");
   a_busy_len: assert property (p_busy_len) else $error("sum busy length wrong");
   a_restart: assert property (p_restart) else $error("restart too short");
   a_stretch_low: assert property (p_stretch_low) else $error("stretch in SCL high");
   a_stretch_len: assert property (p_stretch_len) else $error("stretch too long");
   a_sda_steady: assert property (p_sda_steady) else $error("SDA moved in SCL high");
endmodule

bind afr_top afr_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) afr_checker_i (.CLK(CLK),
   .RST_N(RST_N), .LINK_CLK(LINK_CLK), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .FLOW_READY(FLOW_READY), .SUM_BUSY(SUM_BUSY));

// file: tb/afr_host.sv
// Host bus controller model: two-wire reads and command writes at 400 kHz
module afr_host (
   // Resolved wires
   input wire logic scl,
   input wire logic sda,
   // Host pull-downs
   output logic scl_pull,
   output logic sda_pull,
   // Target stretched beyond the bound
   output logic tmo
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time QTR = 625;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      tmo = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      int n;
      sda_pull = !b;
      #QTR;
      scl_pull = 1'b0;
      n = 0;
      // Honour stretching, but never hang on a stuck target
      while (!scl && n < 4000) begin
         #10;
         n++;
      end
      if (!scl) begin
         tmo = 1'b1;
      end
      #(2 * QTR);
      r = sda;
      scl_pull = 1'b1;
      #QTR;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q,
                          output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack, a);
   endtask
   task automatic xfer(input logic [6:0] adr, input logic rd, input int nb, input logic [7:0] c,
                       output logic [15:0] w, output logic nak);
      logic [7:0] q;
      logic a;
      sda_pull = 1'b1;
      #QTR;
      scl_pull = 1'b1;
      #QTR;
      byte_io({adr, rd}, 1'b1, q, nak);
      if (rd) begin
         byte_io(8'hFF, 1'b0, w[15:8], a);
         byte_io(8'hFF, 1'b1, w[7:0], a);
      end else begin
         for (int i = 0; i < nb; i++) begin
            byte_io(c, 1'b1, q, a);
         end
      end
      sda_pull = 1'b1;
      #QTR;
      scl_pull = 1'b0;
      #QTR;
      sda_pull = 1'b0;
      #QTR;
   endtask
endmodule

// file: tb/afr_top_test.sv
// Self-checking bench of the airflow readout with a host controller model
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module afr_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADR = 7'h2A;
   // Arbitrary unit id for this run
   localparam logic [31:0] ID = 32'hC3A5_1E70;
   localparam int STARTUP = 200;
   localparam int REFRESH = 50;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] flow_frac = 16'h0000;
   logic scl_oe, sda_oe, flow_ready, sum_busy, h_scl, h_sda, h_tmo;
   logic saw_busy = 1'b0;
   int failures = 0;
   int n_checks = 0;
   wire scl = !(scl_oe | h_scl);
   wire sda = !(sda_oe | h_sda);
   always #25 clk = !clk;
   initial begin
      #3.7;
      forever #6 link_clk = !link_clk;
   end
   always @(posedge clk) begin
      if (sum_busy === 1'b1) begin
         saw_busy <= 1'b1;
      end
   end
   afr_top #(.TARGET_ADDR(ADR), .UNIT_ID(ID), .STARTUP_CYCLES(STARTUP), .REFRESH_CYCLES(REFRESH))
   afr_top_i (.CLK(clk), .RST_N(rst_n), .FLOW_FRAC(flow_frac), .LINK_CLK(link_clk), .SCL_IN(scl),
      .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
      .FLOW_READY(flow_ready), .SUM_BUSY(sum_busy));
   afr_host afr_host_i (.scl(scl), .sda(sda), .scl_pull(h_scl), .sda_pull(h_sda), .tmo(h_tmo));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic final_report;
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic bus(input logic rd, input int nb, input logic [7:0] c, output logic [15:0] w);
      logic nak;
      afr_host_i.xfer(ADR, rd, nb, c, w, nak);
      `CHK("address ack", 1'b0, nak)
      if (h_tmo) begin
         failures++;
         final_report;
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (flow_ready !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (flow_ready !== 1'b1) begin
         failures++;
         final_report;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up;
      logic [15:0] w;
      wait_ready();
      bus(1'b1, 0, 8'h00, w);
      `CHK("id high", ID[31:16], w)
      bus(1'b1, 0, 8'h00, w);
      `CHK("id low", ID[15:0], w)
   endtask
   task automatic t_flow;
      logic [15:0] w;
      logic [15:0] fr [3] = '{16'h0000, 16'hFFFF, 16'h4321};
      foreach (fr[i]) begin
         @(posedge clk);
         #1 flow_frac = fr[i];
         // Two refresh periods so the reading is surely fresh
         repeat (2 * REFRESH + 4) @(posedge clk);
         bus(1'b1, 0, 8'h00, w);
         `CHK("flow", 16'((32'(fr[i]) + 32'd8192) / 32'd5), w)
         `CHK("flow top bits", 2'b00, w[15:14])
      end
   endtask
   task automatic t_cmds;
      logic [15:0] w;
      bus(1'b0, 1, 8'h01, w);
      bus(1'b1, 0, 8'h00, w);
      `CHK("unit id high", ID[31:16], w)
      bus(1'b1, 0, 8'h00, w);
      `CHK("unit id low", ID[15:0], w)
      bus(1'b0, 1, 8'h7E, w);
      bus(1'b1, 0, 8'h00, w);
      `CHK("unknown command", 16'hCC99, w)
      `CHK("status top bits", 2'b11, w[15:14])
      bus(1'b0, 2, 8'h01, w);
      bus(1'b1, 0, 8'h00, w);
      `CHK("extra byte", 16'hCC9A, w)
      bus(1'b0, 1, 8'h03, w);
      bus(1'b1, 0, 8'h00, w);
      `CHK("memory sum", 16'hCCA5, w)
      `CHK("sum busy seen", 1'b1, saw_busy)
      bus(1'b1, 0, 8'h00, w);
      `CHK("flow after status", 16'((32'(flow_frac) + 32'd8192) / 32'd5), w)
   endtask
   task automatic t_restart;
      logic [15:0] w;
      bus(1'b0, 1, 8'h02, w);
      `CHK("ready dropped", 1'b0, flow_ready)
      wait_ready();
      bus(1'b1, 0, 8'h00, w);
      `CHK("restart id high", ID[31:16], w)
      bus(1'b1, 0, 8'h00, w);
      `CHK("restart id low", ID[15:0], w)
      bus(1'b1, 0, 8'h00, w);
      `CHK("flow after restart", 16'((32'(flow_frac) + 32'd8192) / 32'd5), w)
   endtask
   task automatic t_wrong_addr;
      logic [15:0] w;
      logic nak;
      afr_host_i.xfer(ADR ^ 7'h01, 1'b1, 0, 8'h00, w, nak);
      `CHK("foreign address", 1'b1, nak)
      `CHK("foreign data", 16'hFFFF, w)
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      t_power_up();
      t_flow();
      t_cmds();
      t_restart();
      t_wrong_addr();
      final_report();
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule
